// ---- hdl/brht_params.svh ----
// constants for the bus reading hold/trigger block
// assumes inclusion by both the package and the main module
`ifndef BRHT_PARAMS_SVH
`define BRHT_PARAMS_SVH
`define BRHT_ADDR_W        5
`define BRHT_ADDR_MAX      5'h1E
`define BRHT_TALK_BASE     8'h40
`define BRHT_LISTEN_BASE   8'h20
`define BRHT_UNTALK        8'h5F
`define BRHT_UNLISTEN      8'h3F
`define BRHT_TRIGGER_CMD   8'h08
`define BRHT_SEL_CLEAR     8'h04
`define BRHT_READING_W     32
`define BRHT_CHAR_W        8
`define BRHT_SAMPLE_DIV    24'h000400
`endif

// ---- hdl/brht_pkg.sv ----
// types for the bus reading hold/trigger block
// assumes brht_params.svh is on the include path
`include "brht_params.svh"
package brht_pkg;
  typedef logic [`BRHT_ADDR_W-1:0] brht_addr_t;
  typedef logic [`BRHT_READING_W-1:0] brht_reading_t;

  // one byte offered by the controller
  typedef struct packed {
    logic       valid;
    logic       atn;
    logic [7:0] data;
  } brht_bus_byte_s;

  typedef enum logic [1:0] {
    BRHT_IDLE,
    BRHT_MEASURE,
    BRHT_HELD
  } brht_meas_e;
endpackage

// ---- hdl/brht_reading_reg.sv ----
// held reading store with registered read port
// assumes a single writer and one clock
`timescale 1ns/10ps
`default_nettype none
module brht_reading_reg
  import brht_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic      [WIDTH-1:0] rd_data
);
  initial begin
    if (WIDTH < 1) $error("width must be positive");
  end

  logic [WIDTH-1:0] mem_reg;

  // store and register the read copy
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem_reg <= '0;
      rd_data <= '0;
    end else begin
      if (wr_en) mem_reg <= wr_data;
      rd_data <= mem_reg;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/brht_top.sv ----
// bus readout logic: talk addressing, hold and free-running readings
// assumes bus bytes arrive decoded and synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
`include "brht_params.svh"
module brht_top
  import brht_pkg::*;
#(
  parameter int SAMPLE_DIV = `BRHT_SAMPLE_DIV
) (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           reset,
  // address switch and mode
  input  wire brht_addr_t     bus_address,
  input  wire logic           single_shot_hold_mode,
  input  wire logic           reset_cmd,
  // bus side
  input  wire brht_bus_byte_s bus_in,
  input  wire logic           ifc,
  input  wire logic           reading_ack,
  // measurement engine
  output logic                meas_start,
  input  wire logic           meas_done,
  input  wire brht_reading_t  meas_value,
  // outputs
  output logic                talker_active,
  output logic                listener_active,
  output logic                address_valid,
  output logic                reading_ready,
  output brht_reading_t       reading_out,
  output brht_reading_t       display_value
);
  initial begin
    if (SAMPLE_DIV < 1 || SAMPLE_DIV > 24'hFFFFFF) $error("bad sample divider");
  end

  localparam logic [23:0] DIV_LAST = 24'(SAMPLE_DIV - 1);

  typedef struct packed {
    brht_meas_e    meas;
    logic [23:0]   rate_cnt;
    logic          talk;
    logic          listen;
    logic          addr_ok;
    logic          ready;
    logic          start;
    logic          wr;
    logic          rdy;
    brht_reading_t display;
  } brht_state_s;

  brht_state_s st_reg;
  brht_state_s st_next;
  brht_reading_t held_rd;

  // talk/listen address for this setting
  function automatic logic [7:0] addr_char(input logic [7:0] base, input brht_addr_t a);
    return base + {3'h0, a};
  endfunction

  // trigger only counts when addressed to listen, or when reset_cmd is asserted
  logic trig;
  assign trig = reset_cmd
    | (bus_in.valid & bus_in.atn & bus_in.data == `BRHT_TRIGGER_CMD & st_reg.listen);

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.wr = 1'b0;
    st_next.addr_ok = (bus_address <= `BRHT_ADDR_MAX);
    if (bus_in.valid && bus_in.atn && st_next.addr_ok) begin
      if (bus_in.data == addr_char(`BRHT_TALK_BASE, bus_address)) begin
        st_next.talk = 1'b1;
      end else if (bus_in.data[7:5] == 3'h2 || bus_in.data == `BRHT_UNTALK) begin
        st_next.talk = 1'b0;                                     // another talker took over, or untalk
      end
      if (bus_in.data == addr_char(`BRHT_LISTEN_BASE, bus_address)) begin
        st_next.listen = 1'b1;
      end else if (bus_in.data == `BRHT_UNLISTEN) begin
        st_next.listen = 1'b0;
      end
    end
    // reading leaves once consumed by a talk-addressed read
    if (reading_ack && st_reg.talk && st_reg.ready) begin
      st_next.ready = 1'b0;
    end
    st_next.rate_cnt = (st_reg.rate_cnt == DIV_LAST) ? 24'h000000 : st_reg.rate_cnt + 24'h000001;
    case (st_reg.meas)
      BRHT_IDLE: begin
        if (!single_shot_hold_mode) begin
          if (st_reg.rate_cnt == DIV_LAST) begin
            st_next.start = 1'b1;
            st_next.meas = BRHT_MEASURE;
          end
        end else begin
          st_next.start = 1'b1;
          st_next.meas = BRHT_MEASURE;
        end
      end
      BRHT_MEASURE: begin
        if (meas_done) begin
          st_next.display = meas_value;
          st_next.wr = 1'b1;
          st_next.ready = 1'b1;
          st_next.meas = single_shot_hold_mode ? BRHT_HELD : BRHT_IDLE;
        end
      end
      BRHT_HELD: begin
        // display frozen; a trigger starts exactly one new reading
        if (trig) begin
          st_next.start = 1'b1;
          st_next.ready = 1'b0;
          st_next.meas = BRHT_MEASURE;
        end else if (!single_shot_hold_mode) begin
          st_next.meas = BRHT_IDLE;
        end
      end
      default: st_next.meas = BRHT_IDLE;
    endcase
    // interface clear drops addressing only, not the reading
    if (ifc) begin
      st_next.talk = 1'b0;
      st_next.listen = 1'b0;
    end
    // registered so the pin comes straight from a flop
    st_next.rdy = st_next.ready & st_next.talk;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.meas <= BRHT_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  brht_reading_reg #(.WIDTH(`BRHT_READING_W)) u_hold (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (st_reg.wr),
    .wr_data  (st_reg.display),
    .rd_data  (held_rd)
  );

  // outputs straight from flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reading_out <= '0;
    end else begin
      reading_out <= held_rd;
    end
  end
  assign talker_active   = st_reg.talk;
  assign listener_active = st_reg.listen;
  assign address_valid   = st_reg.addr_ok;
  assign reading_ready   = st_reg.rdy;
  assign meas_start      = st_reg.start;
  assign display_value   = st_reg.display;
endmodule
`default_nettype wire

// ---- bench/brht_sva.sv ----
// port checker for brht_top
// assumes bind into brht_top
`timescale 1ns/10ps
`default_nettype none
module brht_sva
  import brht_pkg::*;
(
  // watched ports
  input wire logic           core_clk,
  input wire logic           reset,
  input wire brht_addr_t     bus_address,
  input wire logic           single_shot_hold_mode,
  input wire logic           reset_cmd,
  input wire brht_bus_byte_s bus_in,
  input wire logic           ifc,
  input wire logic           listener_active,
  input wire logic           meas_start,
  input wire logic           meas_done,
  input wire brht_reading_t  meas_value,
  input wire logic           talker_active,
  input wire logic           address_valid,
  input wire logic           reading_ready,
  input wire brht_reading_t  reading_out,
  input wire brht_reading_t  display_value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // command decode
  wire logic cmd = bus_in.valid && bus_in.atn;
  wire logic trg = cmd && bus_in.data == 8'h08;
  addr_range_a: assert property (!$past(reset) && $stable(bus_address) |->
    address_valid == (bus_address <= 5'h1E)) else $error("address_valid wrong");
  talk_char_a: assert property (cmd && bus_in.data == 8'h40 + bus_address
    && bus_address <= 5'h1E && !ifc |=> talker_active) else $error("talk missed");
  ifc_clear_a: assert property (ifc |=> !talker_active && !listener_active)
    else $error("clear missed");
  untalk_a: assert property (cmd && bus_in.data == 8'h5F |=> !talker_active)
    else $error("untalk missed");
  // a held reading starts nothing without a trigger
  hold_once_a: assert property (single_shot_hold_mode && meas_start ##1
    (single_shot_hold_mode && !trg && !reset_cmd) [*4] |=> !meas_start) else $error("extra start");
  disp_hold_a: assert property (!meas_done |=> $stable(display_value))
    else $error("display moved");
  disp_upd_a: assert property (meas_done |=> display_value == $past(meas_value))
    else $error("display stale");
  read_out_a: assert property (meas_done |-> ##4 reading_out == $past(meas_value, 4))
    else $error("reading_out stale");
  ready_a: assert property (meas_done && talker_active && !cmd && !ifc |=> reading_ready)
    else $error("ready missed");
endmodule
bind brht_top brht_sva u_sva (.*);
`default_nettype wire

// ---- bench/brht_ctl_model.sv ----
// bus controller model
// assumes bytes go out on falling edges
`timescale 1ns/10ps
`default_nettype none
module brht_ctl_model
  import brht_pkg::*;
(
  // clock
  input  wire logic      core_clk,
  // bus side
  output brht_bus_byte_s bus_in,
  output logic           reading_ack
);
  initial begin
    bus_in = '0;
    reading_ack = 1'b0;
  end
  // one command byte; idle lines carry the inverse so stale data cannot match
  task automatic send(input logic [7:0] d);
    @(negedge core_clk) bus_in = {2'b11, d};
    @(negedge core_clk) bus_in = {2'b00, ~d};
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/brht_top_tb.sv ----
// bench for brht_top
// assumes a stub engine answering each start
`timescale 1ns/10ps
`default_nettype none
module brht_top_tb;
  import brht_pkg::*;
  logic clk = 0, reset = 1, hold = 1, rcmd = 0, done = 0;
  logic talk, lis, av, rdy, start, ack;
  logic ifc_in = 0;
  brht_reading_t v;
  brht_addr_t addr = 5'h13;
  brht_reading_t value = '0, rd, disp;
  brht_bus_byte_s bus;
  int errors = 0, cmp_count = 0;
  // byte, talker, listener
  logic [9:0] rows [6] = '{10'h14E, 10'h0CF, 10'h17D, 10'h0FC, 10'h14E, 10'h104};
  always #2.5 clk = ~clk;
  // stub engine: done one cycle after start
  always @(posedge clk) begin
    done <= (start === 1'b1);
    if (start === 1'b1) value <= value + 32'h1;
  end
  brht_ctl_model u_ctl (.core_clk(clk), .bus_in(bus), .reading_ack(ack));
  brht_top #(.SAMPLE_DIV(4)) u_dut (.core_clk(clk), .reset(reset), .bus_address(addr),
    .single_shot_hold_mode(hold), .reset_cmd(rcmd), .bus_in(bus), .ifc(ifc_in),
    .reading_ack(ack), .meas_start(start), .meas_done(done), .meas_value(value),
    .talker_active(talk), .listener_active(lis), .address_valid(av),
    .reading_ready(rdy), .reading_out(rd), .display_value(disp));
  task automatic chk(input brht_reading_t g, e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    wait_n(2);
    reset = 0;
    chk(rd, '0);
    wait_n(20);
    chk(disp, 32'h1);
    chk(value, 32'h1);
    foreach (rows[i]) begin
      u_ctl.send(rows[i][9:2]);
      chk(32'(talk), 32'(rows[i][1]));
      chk(32'(lis), 32'(rows[i][0]));
    end
    u_ctl.send(8'h33);
    u_ctl.send(8'h53);
    u_ctl.send(8'h08);
    wait_n(6);
    chk(disp, 32'h2);
    chk(rd, 32'h2);
    chk(32'(rdy), 32'h1);
    rcmd = 1;
    wait_n(1);
    rcmd = 0;
    wait_n(6);
    chk(disp, 32'h3);
    hold = 0;
    wait_n(60);
    chk(32'(value > 32'h8), 32'h1);
    @(posedge done);
    wait_n(2);
    v = value;
    chk(disp, v);
    wait_n(3);
    chk(rd, v);
    addr = 5'h1F;
    wait_n(2);
    chk(32'(av), 32'h0);
    addr = 5'h1E;
    u_ctl.send(8'h5F);
    chk(32'(talk), 32'h0);
    u_ctl.send(8'h5E);
    chk(32'(talk), 32'h1);
    // interface clear drops talker and listener
    ifc_in = 1;
    wait_n(1);
    ifc_in = 0;
    chk(32'(talk), 32'h0);
    chk(32'(lis), 32'h0);
    end_sim();
  end
  // watchdog
  initial begin
    #20000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
